// >>> src/pscfg_pkg.sv
// Package of constants for the strap and sync-clock configuration loader.
package pscfg_pkg;
  // ----------------------------------------------------------------------
  // Register map (word index equals byte address here, plain port).
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_GLOBAL_CFG = 4'h0;
  localparam logic [3:0] ADDR_SYNC_CFG = 4'h1;
  localparam logic [3:0] ADDR_MODE_WORD = 4'h2;
  localparam logic [3:0] ADDR_CH0_CFG = 4'h3;
  localparam logic [3:0] ADDR_CH1_CFG = 4'h4;
  localparam logic [3:0] ADDR_CH0_PHASE = 4'h5;
  localparam logic [3:0] ADDR_CH1_PHASE = 4'h6;
  localparam logic [3:0] ADDR_FREQ = 4'h7;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_COMP = 4'h9;
  localparam logic [3:0] ADDR_CH1_VOUT = 4'hA;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int BIT_PULSE_SKIP = 0;
  localparam int BIT_FOLLOWER = 8;
  localparam int BIT_CLK_OUT = 0;
  localparam int BIT_IGNORE_STRAP = 6;
  localparam int RITH_LSB = 3;
  localparam int CITH_LSB = 6;
  localparam int GM_LSB = 11;

  // ----------------------------------------------------------------------
  // Reset (non-volatile default) values and field codes.
  // ----------------------------------------------------------------------
  localparam logic [15:0] MODE_RESET = 16'h1800;
  localparam logic [15:0] FREQ_RESET = 16'h03E8;
  localparam logic [15:0] PHASE0_RESET = 16'h0000;
  localparam logic [15:0] PHASE1_RESET = 16'h00B4;
  localparam logic [15:0] PHASE_180 = 16'h00B4;
  localparam logic [2:0] GM_MAX = 3'h7;
  localparam logic [2:0] RITH_20K = 3'h1;
  localparam logic [2:0] RITH_40K = 3'h2;
  localparam logic [2:0] CITH_80P = 3'h4;
  localparam logic [2:0] CITH_60P = 3'h3;

  // ----------------------------------------------------------------------
  // Strap codes and clock measurement.
  // ----------------------------------------------------------------------
  localparam logic [3:0] STRAP_ARRAY_SEL = 4'hD;
  localparam logic [3:0] STRAP_NVM = 4'h0;
  localparam logic [3:0] STRAP_GM_LIMIT = 4'h1;
  localparam int CLK_HZ = 250_000_000;
  localparam int WIN_US = 100;
  localparam int WIN_CYC = CLK_HZ / 1_000_000 * WIN_US;
  // Edges counted in the window times this gives kHz.
  localparam int KHZ_PER_EDGE = 1000 / WIN_US;
  localparam logic [15:0] BAND1_KHZ = 16'h0271;
  localparam logic [15:0] BAND2_KHZ = 16'h09C4;
  localparam logic [15:0] ROUND_KHZ = 16'h0064;
  localparam logic [15:0] ROUND_HALF = 16'h0032;
  localparam logic [15:0] MIN_EDGES = 16'h0004;

  // Loader sequence states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MEASURE = 3'b001,
    ST_APPLY = 3'b010,
    ST_RUN = 3'b011
  } pscfg_state_t;
endpackage : pscfg_pkg

// >>> src/pscfg_clkmeas.sv
// Sync-clock edge counter over a fixed measurement window.
`timescale 1ns/10ps
`default_nettype none
module pscfg_clkmeas (
  input wire logic core_clk_i, // Core clock.
  input wire logic rstn_i, // Asynchronous reset, active low.
  input wire logic start_i, // Starts one window.
  input wire logic sync_i, // Sync pin level, already synchronous.
  output logic done_o, // Window complete pulse.
  output logic [15:0] edges_o // Rising edges counted.
);
  logic [31:0] win_cnt;
  logic busy;
  logic sync_d;

  // Window timer and rising-edge counter.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      win_cnt <= 32'h0000_0000;
      busy <= 1'b0;
      sync_d <= 1'b0;
      edges_o <= 16'h0000;
      done_o <= 1'b0;
    end
    else
    begin
      sync_d <= sync_i;
      done_o <= 1'b0;
      if (start_i)
      begin
        busy <= 1'b1;
        win_cnt <= 32'h0000_0000;
        edges_o <= 16'h0000;
      end
      else if (busy)
      begin
        if (sync_i && !sync_d)
          edges_o <= edges_o + 16'h0001;
        win_cnt <= win_cnt + 32'h0000_0001;
        if (win_cnt == 32'(pscfg_pkg::WIN_CYC - 1))
        begin
          busy <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule : pscfg_clkmeas
`default_nettype wire

// >>> src/pscfg_phase.sv
// Phase generator: delays a switch pulse from each reference rising edge.
`timescale 1ns/10ps
`default_nettype none
module pscfg_phase (
  input wire logic core_clk_i, // Core clock.
  input wire logic rstn_i, // Asynchronous reset, active low.
  input wire logic ref_i, // Reference clock level.
  input wire logic [15:0] period_i, // Reference period in cycles.
  input wire logic [15:0] phase_i, // Phase in degrees.
  output logic sw_o // Switch-node start pulse.
);
  logic ref_d;
  logic [15:0] delay;
  logic [15:0] cnt;
  logic armed;
  logic [31:0] prod;

  // Widen both factors so the product keeps all 32 bits.
  assign prod = 32'(period_i) * 32'(phase_i);

  // Count delay after each rising edge, then pulse.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ref_d <= 1'b0;
      delay <= 16'h0000;
      cnt <= 16'h0000;
      armed <= 1'b0;
      sw_o <= 1'b0;
    end
    else
    begin
      ref_d <= ref_i;
      sw_o <= 1'b0;
      if (ref_i && !ref_d)
      begin
        delay <= 16'(prod / 32'h0000_0168); // Degrees in one period.
        cnt <= 16'h0000;
        armed <= 1'b1;
      end
      else if (armed)
      begin
        cnt <= cnt + 16'h0001;
        if (cnt >= delay)
        begin
          armed <= 1'b0;
          sw_o <= 1'b1;
        end
      end
    end
  end
endmodule : pscfg_phase
`default_nettype wire

// >>> src/pscfg_top.sv
// Start-up strap decode, sync clock measure and configuration registers.
`timescale 1ns/10ps
`default_nettype none
module pscfg_top (
  input wire logic core_clk_i, // Core clock, 250 MHz.
  input wire logic rstn_i, // Asynchronous reset, active low.
  input wire logic [3:0] sync_strap_i, // Decoded sync pin strap code.
  input wire logic [3:0] ch1_voltage_or_array_strap_i, // Ch1 strap code.
  input wire logic [3:0] ch0_voltage_strap_i, // Ch0 strap code.
  input wire logic error_amp_output_pin_i, // High when tied to supply.
  input wire logic sync_pin_i, // Sync pin input level.
  output logic sync_pin_o, // Sync pin output level.
  output logic sync_pin_oe_o, // Sync pin output enable.
  output logic sw0_o, // Channel 0 switch start pulse.
  output logic sw1_o, // Channel 1 switch start pulse.
  output logic forced_continuous_o, // Light-load mode is continuous.
  output logic [2:0] comp_cap_o, // Compensation capacitor code.
  output logic [2:0] comp_res_o, // Compensation resistor code.
  output logic [2:0] comp_gm_o, // Transconductance code.
  output logic init_done_o, // Configuration loaded.
  input wire logic [3:0] addr_i, // Register address.
  input wire logic [15:0] wdata_i, // Write data.
  input wire logic wr_i, // Write strobe.
  input wire logic rd_i, // Read strobe.
  output logic [15:0] rdata_o // Read data, one cycle later.
);
  // ----------------------------------------------------------------------
  // State and registers.
  // ----------------------------------------------------------------------
  pscfg_pkg::pscfg_state_t state;
  logic [15:0] global_config_word;
  logic [15:0] sync_config_word;
  logic [15:0] switching_mode_word;
  logic [15:0] channel_config_word0;
  logic [15:0] channel_config_word1;
  logic [15:0] channel_phase_word0;
  logic [15:0] channel_phase_word1;
  logic [15:0] freq_word;
  logic [15:0] strap_fault_status;
  logic [15:0] ch1_vout_src;
  logic [2:0] meas_cap;
  logic [2:0] meas_res;
  logic meas_comp;
  logic clk_seen;
  logic meas_start;
  logic meas_done;
  logic [15:0] edges;
  logic [15:0] khz;
  logic [15:0] rounded;
  logic [15:0] period;
  logic [15:0] div_cnt;
  logic clk_gen;
  logic ref_clk;
  logic sw0;
  logic sw1;
  logic ignore_strap;
  logic array_mode;

  // Strap decode helper used by the transconductance limit decision.
  function automatic logic strap_low_r(input logic [3:0] code);
    strap_low_r = (code != pscfg_pkg::STRAP_NVM) &&
                  (code <= pscfg_pkg::STRAP_GM_LIMIT);
  endfunction : strap_low_r

  assign ignore_strap = global_config_word[pscfg_pkg::BIT_IGNORE_STRAP];
  assign array_mode = !ignore_strap &&
                      (sync_strap_i == pscfg_pkg::STRAP_ARRAY_SEL);

  assign khz = 16'(edges * 16'(pscfg_pkg::KHZ_PER_EDGE));
  assign rounded = 16'(((khz + pscfg_pkg::ROUND_HALF) /
                  pscfg_pkg::ROUND_KHZ) * pscfg_pkg::ROUND_KHZ);
  // Period in core cycles of the running switching clock.
  assign period = (freq_word == 16'h0000) ? 16'hFFFF :
                  16'(32'(pscfg_pkg::CLK_HZ / 1000) / 32'(freq_word));

  // ----------------------------------------------------------------------
  // Clock measurement.
  // ----------------------------------------------------------------------
  pscfg_clkmeas u_meas (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .start_i(meas_start),
    .sync_i(sync_pin_i),
    .done_o(meas_done),
    .edges_o(edges)
  );

  // Loader sequence: measure once, apply once, then run until reset.
  // sample once
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= pscfg_pkg::ST_IDLE;
      meas_start <= 1'b0;
      init_done_o <= 1'b0;
    end
    else
    begin
      meas_start <= 1'b0;
      case (state)
        pscfg_pkg::ST_IDLE:
        begin
          meas_start <= 1'b1;
          state <= pscfg_pkg::ST_MEASURE;
        end
        pscfg_pkg::ST_MEASURE:
          if (meas_done)
            state <= pscfg_pkg::ST_APPLY;
        pscfg_pkg::ST_APPLY:
        begin
          init_done_o <= 1'b1;
          state <= pscfg_pkg::ST_RUN;
        end
        pscfg_pkg::ST_RUN:
          state <= pscfg_pkg::ST_RUN;
        default:
          state <= pscfg_pkg::ST_IDLE;
      endcase
    end
  end

  // Clock-presence flag, taken once at the end of the window.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      clk_seen <= 1'b0;
    else if (state == pscfg_pkg::ST_MEASURE && meas_done)
      clk_seen <= (edges >= pscfg_pkg::MIN_EDGES);
  end

  // Configuration words: mode, channel, phase, frequency and ch1_vout_src loaded at apply; all but ch1_vout_src writable after.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      global_config_word <= 16'h0000;
      sync_config_word <= 16'h0000;
      switching_mode_word <= pscfg_pkg::MODE_RESET;
      channel_config_word0 <= 16'h0000;
      channel_config_word1 <= 16'h0000;
      channel_phase_word0 <= pscfg_pkg::PHASE0_RESET;
      channel_phase_word1 <= pscfg_pkg::PHASE1_RESET;
      freq_word <= pscfg_pkg::FREQ_RESET;
      ch1_vout_src <= 16'h0000;
      meas_cap <= pscfg_pkg::CITH_80P;
      meas_res <= pscfg_pkg::RITH_40K;
      meas_comp <= 1'b0;
    end
    else if (state == pscfg_pkg::ST_APPLY)
    begin
      ch1_vout_src <= array_mode ? {12'h000, ch0_voltage_strap_i} :
                      {12'h000, ch1_voltage_or_array_strap_i};
      if (array_mode)
      begin
        channel_config_word1[pscfg_pkg::BIT_FOLLOWER] <= 1'b1;
        channel_config_word0[pscfg_pkg::BIT_FOLLOWER] <=
          ch1_voltage_or_array_strap_i[3];
      end
      if (!ignore_strap && clk_seen)
      begin
        freq_word <= rounded;
        channel_phase_word0 <= 16'h0000;
        channel_phase_word1 <= pscfg_pkg::PHASE_180;
        switching_mode_word[pscfg_pkg::BIT_PULSE_SKIP] <= 1'b0;
        meas_comp <= 1'b1;
        meas_res <= (khz < pscfg_pkg::BAND1_KHZ) ? pscfg_pkg::RITH_20K :
                    pscfg_pkg::RITH_40K;
        meas_cap <= (khz > pscfg_pkg::BAND2_KHZ) ? pscfg_pkg::CITH_60P :
                    pscfg_pkg::CITH_80P;
      end
    end
    else if (wr_i && state == pscfg_pkg::ST_RUN)
    begin
      case (addr_i)
        pscfg_pkg::ADDR_GLOBAL_CFG: global_config_word <= wdata_i;
        pscfg_pkg::ADDR_SYNC_CFG: sync_config_word <= wdata_i;
        pscfg_pkg::ADDR_MODE_WORD: switching_mode_word <= wdata_i;
        pscfg_pkg::ADDR_CH0_CFG: channel_config_word0 <= wdata_i;
        pscfg_pkg::ADDR_CH1_CFG: channel_config_word1 <= wdata_i;
        pscfg_pkg::ADDR_CH0_PHASE: channel_phase_word0 <= wdata_i;
        pscfg_pkg::ADDR_CH1_PHASE: channel_phase_word1 <= wdata_i;
        pscfg_pkg::ADDR_FREQ: freq_word <= wdata_i;
        default: ;
      endcase
    end
  end

  // activity change flagged as a strap fault; a write to ADDR_STATUS clears it.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      strap_fault_status <= 16'h0000;
    else if (state == pscfg_pkg::ST_MEASURE && meas_done &&
             edges != 16'h0000 && edges < pscfg_pkg::MIN_EDGES)
      strap_fault_status <= 16'h0001;
    else if (wr_i && addr_i == pscfg_pkg::ADDR_STATUS)
      strap_fault_status <= 16'h0000;
  end

  // Internal switching clock divider; half period per toggle.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      div_cnt <= 16'h0000;
      clk_gen <= 1'b0;
    end
    else if (div_cnt >= {1'b0, period[15:1]})
    begin
      div_cnt <= 16'h0000;
      clk_gen <= !clk_gen;
    end
    else
      div_cnt <= div_cnt + 16'h0001;
  end

  // sync edge reference when clock is present and clock out is off, else own clock.
  assign ref_clk = (clk_seen && !sync_config_word[pscfg_pkg::BIT_CLK_OUT])
                   ? sync_pin_i : clk_gen;

  pscfg_phase u_ph0 (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .ref_i(ref_clk),
    .period_i(period),
    .phase_i(channel_phase_word0),
    .sw_o(sw0)
  );

  pscfg_phase u_ph1 (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .ref_i(ref_clk),
    .period_i(period),
    .phase_i(channel_phase_word1),
    .sw_o(sw1)
  );

  // Registered outputs: pin drive, mode and compensation.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync_pin_o <= 1'b0;
      sync_pin_oe_o <= 1'b0;
      sw0_o <= 1'b0;
      sw1_o <= 1'b0;
      forced_continuous_o <= 1'b1;
      comp_cap_o <= 3'h0;
      comp_res_o <= 3'h0;
      comp_gm_o <= 3'h0;
    end
    else
    begin
      sync_pin_oe_o <= sync_config_word[pscfg_pkg::BIT_CLK_OUT];
      sync_pin_o <= clk_gen;
      sw0_o <= sw0;
      sw1_o <= sw1;
      forced_continuous_o <= !switching_mode_word[pscfg_pkg::BIT_PULSE_SKIP];
      if (meas_comp)
      begin
        comp_cap_o <= meas_cap;
        comp_res_o <= meas_res;
      end
      else
      begin
        comp_cap_o <= switching_mode_word[pscfg_pkg::CITH_LSB +: 3];
        comp_res_o <= switching_mode_word[pscfg_pkg::RITH_LSB +: 3];
      end
      if (!error_amp_output_pin_i && !ignore_strap &&
          strap_low_r(sync_strap_i))
        comp_gm_o <= pscfg_pkg::GM_MAX;
      else
        comp_gm_o <= switching_mode_word[pscfg_pkg::GM_LSB +: 3];
    end
  end

  // Register read port with one cycle latency.
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= 16'h0000;
    else if (rd_i)
    begin
      case (addr_i)
        pscfg_pkg::ADDR_GLOBAL_CFG: rdata_o <= global_config_word;
        pscfg_pkg::ADDR_SYNC_CFG: rdata_o <= sync_config_word;
        pscfg_pkg::ADDR_MODE_WORD: rdata_o <= switching_mode_word;
        pscfg_pkg::ADDR_CH0_CFG: rdata_o <= channel_config_word0;
        pscfg_pkg::ADDR_CH1_CFG: rdata_o <= channel_config_word1;
        pscfg_pkg::ADDR_CH0_PHASE: rdata_o <= channel_phase_word0;
        pscfg_pkg::ADDR_CH1_PHASE: rdata_o <= channel_phase_word1;
        pscfg_pkg::ADDR_FREQ: rdata_o <= freq_word;
        pscfg_pkg::ADDR_STATUS: rdata_o <= strap_fault_status;
        pscfg_pkg::ADDR_COMP:
          rdata_o <= {7'h00, comp_gm_o, comp_cap_o, comp_res_o};
        pscfg_pkg::ADDR_CH1_VOUT: rdata_o <= ch1_vout_src;
        default: rdata_o <= 16'h0000;
      endcase
    end
    else
      rdata_o <= 16'h0000;
  end
endmodule : pscfg_top
`default_nettype wire

// >>> verification/pscfg_sync_src.sv
// Behavioural model of the external sync clock source on the shared pin.
`timescale 1ns/10ps
`default_nettype none
module pscfg_sync_src #(
  parameter int HALF_NS = 150
) (
  input wire logic en_i, // Source enabled.
  input wire logic dev_oe_i, // Device drives the pin.
  output logic clk_o // Source level on the pin.
);
  // steady or silent.
  // Enable is only changed in reset, so activity never changes mid-load.
  // When released the strap resistor pulls the pin low, so idle is 0.
  initial
  begin
    clk_o = 1'b0;
    #1.3;
    forever
    begin
      #HALF_NS;
      clk_o = (en_i && !dev_oe_i) ? !clk_o : 1'b0;
    end
  end
endmodule : pscfg_sync_src
`default_nettype wire

// >>> verification/pscfg_props.sv
// Port-level checker for the strap and sync configuration loader.
`timescale 1ns/10ps
`default_nettype none
module pscfg_props (
  input wire logic core_clk_i, // Clock.
  input wire logic rstn_i, // Reset, active low.
  input wire logic [3:0] sync_strap_i, // Sync strap code.
  input wire logic error_amp_output_pin_i, // Compensation select.
  input wire logic sync_pin_o, // Pin output level.
  input wire logic sync_pin_oe_o, // Pin output enable.
  input wire logic sw0_o, // Channel 0 pulse.
  input wire logic sw1_o, // Channel 1 pulse.
  input wire logic forced_continuous_o, // Light-load mode.
  input wire logic [2:0] comp_gm_o, // Transconductance code.
  input wire logic [2:0] comp_cap_o, // Capacitor code.
  input wire logic init_done_o, // Loaded.
  input wire logic wr_i, // Write strobe.
  input wire logic rd_i, // Read strobe.
  input wire logic [15:0] rdata_o // Read data.
);
  // ----------------------------------------------------------------
  // Properties, all in the core clock domain.
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Read data only stands in the cycle after a read.
  rdata_idle_a:
    assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not zero outside a read answer");
  done_sticky_a:
    assert property (init_done_o |=> init_done_o)
    else $error("load done dropped without reset");
  sw0_pulse_a:
    assert property (sw0_o |=> !sw0_o)
    else $error("channel 0 pulse longer than one cycle");
  sw1_pulse_a:
    assert property (sw1_o |=> !sw1_o)
    else $error("channel 1 pulse longer than one cycle");
  oe_idle_a:
    assert property (!init_done_o |-> !sync_pin_oe_o)
    else $error("sync pin driven before load");
  clk_out_a:
    assert property ($rose(sync_pin_oe_o) |-> ##[1:600] $changed(sync_pin_o))
    else $error("sync pin driven but no clock seen");
  fcm_init_a:
    assert property (!init_done_o |-> forced_continuous_o)
    else $error("mode not continuous during load");
  // The limit case holds whatever the mode word says.
  gm_limit_a:
    assert property (init_done_o && !error_amp_output_pin_i &&
      sync_strap_i == pscfg_pkg::STRAP_GM_LIMIT |->
      comp_gm_o == pscfg_pkg::GM_MAX)
    else $error("transconductance not at maximum");
  comp_hold_a:
    assert property (init_done_o && $past(init_done_o, 2) && !$past(wr_i) &&
      !$past(wr_i, 2) |-> $stable(comp_cap_o))
    else $error("capacitor code moved without a write");

  cover property ($rose(init_done_o));
  cover property (sw1_o);
  cover property (sync_pin_oe_o && sync_pin_o);
endmodule : pscfg_props
`default_nettype wire

// >>> verification/pscfg_top_tb.sv
// Self-checking testbench of the strap and sync configuration loader.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected %0t got %h exp %h", $time, (a), (b)); end end
module pscfg_top_tb;
  logic core_clk_i, rstn_i, eamp, wr_i, rd_i, src_en, src_clk, sync_pin;
  logic sync_o, sync_oe, sw0, sw1, forced_continuous, done;
  logic [3:0] sstrap, s1, s0, addr_i;
  logic [15:0] wdata_i, rdata, rv;
  logic [2:0] cap, res, gm;
  int error_cnt = 0;
  int comparisons = 0;

  // The pin carries the device clock when enabled, else the source.
  assign sync_pin = sync_oe ? sync_o : src_clk;

  pscfg_top dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .sync_strap_i(sstrap), .ch1_voltage_or_array_strap_i(s1),
    .ch0_voltage_strap_i(s0), .error_amp_output_pin_i(eamp),
    .sync_pin_i(sync_pin), .sync_pin_o(sync_o), .sync_pin_oe_o(sync_oe),
    .sw0_o(sw0), .sw1_o(sw1), .forced_continuous_o(forced_continuous), .comp_cap_o(cap),
    .comp_res_o(res), .comp_gm_o(gm), .init_done_o(done), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata));
  pscfg_sync_src #(.HALF_NS(150)) u_src (.en_i(src_en), .dev_oe_i(sync_oe),
    .clk_o(src_clk));

  initial
  begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------------------------------
  // Bus and check tasks.
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    rd_reg(a, rv);
    `CHK(rv, e)
  endtask : rd_chk

  // Straps only change in reset; a write during load must be ignored.
  task automatic do_reset(input logic [3:0] st, c1, c0, input logic ea, ce);
    int n;
    @(posedge core_clk_i);
    rstn_i <= 1'b0;
    sstrap <= st;
    s1 <= c1;
    s0 <= c0;
    eamp <= ea;
    src_en <= ce;
    repeat (12) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    wr_reg(pscfg_pkg::ADDR_FREQ, 16'h1234);
    for (n = 0; n < 30000 && done !== 1'b1; n++) @(posedge core_clk_i);
    if (n == 30000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : do_reset

  // Cycles from a sync rise to the chosen channel's pulse.
  task automatic phase_chk(input bit ch, input int lo, input int hi);
    int n;
    for (n = 0; n < 200 && sync_pin !== 1'b0; n++) @(posedge core_clk_i);
    `CHK(sync_pin, 1'b0)
    for (n = 0; n < 200 && sync_pin !== 1'b1; n++) @(posedge core_clk_i);
    `CHK(sync_pin, 1'b1)
    for (n = 0; n < 200; n++)
    begin
      @(posedge core_clk_i);
      if ((ch ? sw1 : sw0) === 1'b1) break;
    end
    `CHK(n >= lo && n <= hi, 1'b1)
  endtask : phase_chk

  // ----------------------------------------------------------------
  // Main sequence: no clock, measured clock, array strap.
  // ----------------------------------------------------------------
  initial
  begin
    rstn_i = 1'b0;
    {wr_i, rd_i, eamp, src_en} = 4'h0;
    {addr_i, sstrap, s1, s0} = 16'h0000;
    wdata_i = 16'h0000;
    do_reset(pscfg_pkg::STRAP_GM_LIMIT, 4'h5, 4'h2, 1'b0, 1'b0);
    rd_chk(pscfg_pkg::ADDR_FREQ, pscfg_pkg::FREQ_RESET);
    rd_chk(pscfg_pkg::ADDR_MODE_WORD, pscfg_pkg::MODE_RESET);
    `CHK(gm, pscfg_pkg::GM_MAX)
    rd_chk(pscfg_pkg::ADDR_CH1_VOUT, 16'h0005);
    for (int b = 1; b >= 0; b--)
    begin
      wr_reg(pscfg_pkg::ADDR_MODE_WORD, pscfg_pkg::MODE_RESET | 16'(b));
      repeat (3) @(posedge core_clk_i);
      `CHK(forced_continuous, b == 0)
    end
    wr_reg(pscfg_pkg::ADDR_CH0_CFG, 16'h0100);
    rd_chk(pscfg_pkg::ADDR_CH0_CFG, 16'h0100);
    wr_reg(pscfg_pkg::ADDR_SYNC_CFG, 16'h0001);
    repeat (3) @(posedge core_clk_i);
    `CHK(sync_oe, 1'b1)
    repeat (600) @(posedge core_clk_i);
    wr_reg(pscfg_pkg::ADDR_SYNC_CFG, 16'h0000);
    repeat (3) @(posedge core_clk_i);
    `CHK(sync_oe, 1'b0)
    rd_chk(4'hF, 16'h0000);
    // A 3.33 MHz source counts 333 or 334 edges; both round to 3300 kHz.
    do_reset(pscfg_pkg::STRAP_NVM, 4'h5, 4'h2, 1'b1, 1'b1);
    rd_chk(pscfg_pkg::ADDR_FREQ, 16'h0CE4);
    rd_chk(pscfg_pkg::ADDR_CH0_PHASE, 16'h0000);
    rd_chk(pscfg_pkg::ADDR_CH1_PHASE, pscfg_pkg::PHASE_180);
    `CHK(forced_continuous, 1'b1)
    `CHK(cap, pscfg_pkg::CITH_60P)
    `CHK(res, pscfg_pkg::RITH_40K)
    phase_chk(1'b0, 0, 8);
    phase_chk(1'b1, 34, 48);
    wr_reg(pscfg_pkg::ADDR_CH1_PHASE, 16'h005A);
    phase_chk(1'b1, 16, 30);
    wr_reg(pscfg_pkg::ADDR_CH1_PHASE, pscfg_pkg::PHASE_180);
    phase_chk(1'b1, 34, 48);
    do_reset(pscfg_pkg::STRAP_ARRAY_SEL, 4'h8, 4'h3, 1'b1, 1'b0);
    rd_chk(pscfg_pkg::ADDR_CH1_VOUT, 16'h0003);
    rd_reg(pscfg_pkg::ADDR_CH1_CFG, rv);
    `CHK(rv[8], 1'b1)
    rd_reg(pscfg_pkg::ADDR_CH0_CFG, rv);
    `CHK(rv[8], 1'b1)
    `CHK(cap, pscfg_pkg::MODE_RESET[8:6])
    `CHK(gm, pscfg_pkg::MODE_RESET[13:11])
    wr_reg(pscfg_pkg::ADDR_MODE_WORD, 16'h2898);
    repeat (3) @(posedge core_clk_i);
    `CHK({cap, res, gm}, 9'h09D)
    tally_and_finish();
  end
endmodule : pscfg_top_tb

bind pscfg_top pscfg_props u_props (.core_clk_i, .rstn_i, .sync_strap_i,
  .error_amp_output_pin_i, .sync_pin_o, .sync_pin_oe_o, .sw0_o, .sw1_o,
  .forced_continuous_o, .comp_gm_o, .comp_cap_o, .init_done_o, .wr_i,
  .rd_i, .rdata_o);
`default_nettype wire
